// File: interval_timer_pkg.sv
// Constants, field positions and types for the interval timer
package interval_timer_pkg;

  // ************************************************
  // Sizes
  // ************************************************
  localparam int COUNTERS = 3;
  localparam int COUNT_W = 16;
  localparam int BUS_W = 8;

  // ************************************************
  // Address and control word encodings
  // ************************************************
  localparam logic [1:0] SEL_CONTROL = 2'h3;
  localparam logic [1:0] SC_READBACK = 2'h3;
  localparam logic [1:0] ACC_LATCH = 2'h0;
  localparam logic [1:0] ACC_LOW = 2'h1;
  localparam logic [1:0] ACC_HIGH = 2'h2;
  localparam logic [1:0] ACC_BOTH = 2'h3;
  localparam int CW_SC = 6;
  localparam int CW_ACC = 4;
  localparam int CW_MODE = 1;
  localparam int CW_BCD = 0;
  localparam int RB_NO_COUNT = 5;
  localparam int RB_NO_STATUS = 4;
  localparam int RB_SEL = 1;

  // ************************************************
  // Count values and steps
  // ************************************************
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [15:0] COUNT_TWO = 16'h0002;
  localparam logic [1:0] STEP_ONE = 2'h1;
  localparam logic [1:0] STEP_TWO = 2'h2;
  localparam logic [3:0] BCD_WRAP = 4'ha;

  typedef enum logic [2:0] {
    MODE_TERMINAL = 3'h0,
    MODE_ONESHOT = 3'h1,
    MODE_RATE = 3'h2,
    MODE_SQUARE = 3'h3,
    MODE_SOFT_STROBE = 3'h4,
    MODE_HARD_STROBE = 3'h5
  } mode_t;

  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [1:0] sel;
    logic [7:0] data;
    logic [2:0] clk;
    logic [2:0] gate;
  } pins_t;

endpackage : interval_timer_pkg

// File: programmable_interval_timer.sv
// Three-counter programmable interval timer with strobe bus interface
//
// Overview of operation
// - Three identical 16-bit counters, each programmed into any of six modes on its own.
// - Each counter counts in binary or BCD as chosen by its control word.
// - Read and write strobes are ignored unless chip select is low with them.
// - Register select 11 addresses the control word, other codes a counter.
// - The control word register cannot be read back.
// - A write with chip select low at select 11 captures the data bus as a control word.
// - Control words program counters, and include counter latch and read-back of status.
// - The processor reads a counter with the read strobe and loads with the write strobe.
// - Each counter has its own clock, gate and output and depends on no other.
// - The output enable goes low only while valid read data stands on the read bus.
// - Each counter holds control, counting element, read latch, load register, status.
module programmable_interval_timer
  import interval_timer_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Processor bus
  input wire logic CHIP_SELECT_N,
  input wire logic READ_STROBE_N,
  input wire logic WRITE_STROBE_N,
  input wire logic [1:0] REGISTER_SELECT,
  input wire logic [BUS_W-1:0] WRITE_BUS,
  output logic [BUS_W-1:0] READ_BUS,
  output logic READ_DRIVE_ENABLE_N,
  // Counter pins
  input wire logic [COUNTERS-1:0] COUNTER_CLOCK,
  input wire logic [COUNTERS-1:0] COUNTER_GATE,
  output logic [COUNTERS-1:0] COUNTER_WAVE
);

  // ************************************************
  // Functions
  // ************************************************
  // Decrement by one or two, digit-wise with borrow in BCD
  function automatic logic [15:0] count_down(input logic [15:0] v,
                                             input logic bcd_mode,
                                             input logic [1:0] step);
    logic [15:0] r;
    logic [4:0] d;
    logic [1:0] b;
    r = COUNT_ZERO;
    b = step;
    d = '0;
    if (!bcd_mode) begin
      r = v - {14'h0000, step};
    end else begin
      for (int k = 0; k < 4; k++) begin
        d = {1'b0, v[4*k +: 4]} - {3'h0, b};
        if (d[4]) begin
          r[4*k +: 4] = d[3:0] + BCD_WRAP;
          b = STEP_ONE;
        end else begin
          r[4*k +: 4] = d[3:0];
          b = 2'h0;
        end
      end
    end
    return r;
  endfunction : count_down

  // Codes 110 and 111 alias the rate and square modes
  function automatic mode_t norm_mode(input logic [2:0] m);
    return m[1] ? mode_t'({1'b0, m[1:0]}) : mode_t'(m);
  endfunction : norm_mode

  // ************************************************
  // Pin synchronisers
  // ************************************************
  pins_t pins;
  pins_t meta;
  pins_t s;

  assign pins = '{cs_n: CHIP_SELECT_N, rd_n: READ_STROBE_N,
                  wr_n: WRITE_STROBE_N, sel: REGISTER_SELECT,
                  data: WRITE_BUS, clk: COUNTER_CLOCK,
                  gate: COUNTER_GATE};

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      meta <= '1;
      s <= '1;
    end else begin
      meta <= pins;
      s <= meta;
    end
  end

  // ************************************************
  // Bus strobes
  // ************************************************
  logic wr_act;
  logic rd_act;
  logic wr_prev;
  logic rd_prev;
  logic wr_done;
  logic rd_start;
  logic rd_done;
  logic [BUS_W-1:0] wdata;
  logic [1:0] wsel;
  logic [1:0] rsel;
  logic rd_valid;
  logic [COUNTERS-1:0] clk_prev;
  logic [COUNTERS-1:0] gate_prev;
  logic [COUNTERS-1:0] tick;
  logic [COUNTERS-1:0] gate_rise;

  assign wr_act = !s.cs_n && !s.wr_n;
  assign rd_act = !s.cs_n && !s.rd_n;
  // Writes act at the trailing edge so the data has settled
  assign wr_done = wr_prev && !wr_act;
  assign rd_start = rd_act && !rd_prev;
  assign rd_done = rd_prev && !rd_act;
  assign tick = clk_prev & ~s.clk;
  assign gate_rise = ~gate_prev & s.gate;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      wr_prev <= 1'b0;
      rd_prev <= 1'b0;
      wdata <= '0;
      wsel <= '0;
      rsel <= '0;
      clk_prev <= '1;
      gate_prev <= '1;
    end else begin
      wr_prev <= wr_act;
      rd_prev <= rd_act;
      clk_prev <= s.clk;
      gate_prev <= s.gate;
      if (wr_act) begin
        wdata <= s.data;
        wsel <= s.sel;
      end
      if (rd_start) begin
        rsel <= s.sel;
      end
    end
  end

  // ************************************************
  // Counter state
  // ************************************************
  logic [COUNT_W-1:0] count [COUNTERS];
  logic [COUNT_W-1:0] reload [COUNTERS];
  logic [COUNT_W-1:0] latched [COUNTERS];
  logic [BUS_W-1:0] status [COUNTERS];
  logic [1:0] acc [COUNTERS];
  mode_t mode [COUNTERS];
  logic [COUNT_W-1:0] dec1 [COUNTERS];
  logic [COUNT_W-1:0] dec2 [COUNTERS];
  logic [COUNTERS-1:0] bcd;
  logic [COUNTERS-1:0] out;
  logic [COUNTERS-1:0] null_cnt;
  logic [COUNTERS-1:0] pend;
  logic [COUNTERS-1:0] loaded;
  logic [COUNTERS-1:0] run;
  logic [COUNTERS-1:0] fired;
  logic [COUNTERS-1:0] trig;
  logic [COUNTERS-1:0] wr_hi;
  logic [COUNTERS-1:0] rd_hi;
  logic [COUNTERS-1:0] latch_flag;
  logic [COUNTERS-1:0] status_flag;

  always_comb begin
    for (int i = 0; i < COUNTERS; i++) begin
      dec1[i] = count_down(count[i], bcd[i], STEP_ONE);
      dec2[i] = count_down(count[i], bcd[i], STEP_TWO);
    end
  end

  // One loop body serves all three counters alike
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      for (int i = 0; i < COUNTERS; i++) begin
        count[i] <= COUNT_ZERO;
        reload[i] <= COUNT_ZERO;
        latched[i] <= COUNT_ZERO;
        status[i] <= '0;
        acc[i] <= ACC_LATCH;
        mode[i] <= MODE_TERMINAL;
      end
      bcd <= '0;
      out <= '0;
      null_cnt <= '0;
      pend <= '0;
      loaded <= '0;
      run <= '0;
      fired <= '0;
      trig <= '0;
      wr_hi <= '0;
      rd_hi <= '0;
      latch_flag <= '0;
      status_flag <= '0;
    end else begin
      for (int i = 0; i < COUNTERS; i++) begin
        // Gate edge held until the next counter clock; set wins
        if (tick[i]) trig[i] <= 1'b0;
        if (gate_rise[i]) trig[i] <= 1'b1;

        if (tick[i]) begin
          unique case (mode[i])
            MODE_TERMINAL, MODE_SOFT_STROBE: begin
              if (pend[i]) begin
                count[i] <= reload[i];
                pend[i] <= 1'b0;
                null_cnt[i] <= 1'b0;
                run[i] <= 1'b1;
                fired[i] <= 1'b0;
              end else if (run[i] && s.gate[i]) begin
                count[i] <= dec1[i];
                if (mode[i] == MODE_TERMINAL) begin
                  if (dec1[i] == COUNT_ZERO) out[i] <= 1'b1;
                end else begin
                  out[i] <= !(dec1[i] == COUNT_ZERO && !fired[i]);
                  if (dec1[i] == COUNT_ZERO) fired[i] <= 1'b1;
                end
              end
            end
            MODE_ONESHOT, MODE_HARD_STROBE: begin
              if (trig[i] && loaded[i]) begin
                count[i] <= reload[i];
                pend[i] <= 1'b0;
                null_cnt[i] <= 1'b0;
                run[i] <= 1'b1;
                fired[i] <= 1'b0;
                if (mode[i] == MODE_ONESHOT) out[i] <= 1'b0;
              end else if (run[i]) begin
                count[i] <= dec1[i];
                if (mode[i] == MODE_ONESHOT) begin
                  if (dec1[i] == COUNT_ZERO) out[i] <= 1'b1;
                end else begin
                  out[i] <= !(dec1[i] == COUNT_ZERO && !fired[i]);
                  if (dec1[i] == COUNT_ZERO) fired[i] <= 1'b1;
                end
              end
            end
            MODE_RATE: begin
              if ((pend[i] && !run[i]) || (trig[i] && loaded[i])) begin
                count[i] <= reload[i];
                pend[i] <= 1'b0;
                null_cnt[i] <= 1'b0;
                run[i] <= 1'b1;
                out[i] <= 1'b1;
              end else if (run[i] && s.gate[i]) begin
                if (count[i] == COUNT_ONE) begin
                  count[i] <= reload[i];
                  pend[i] <= 1'b0;
                  null_cnt[i] <= 1'b0;
                  out[i] <= 1'b1;
                end else begin
                  count[i] <= dec1[i];
                  out[i] <= dec1[i] != COUNT_ONE;
                end
              end
            end
            MODE_SQUARE: begin
              if ((pend[i] && !run[i]) || (trig[i] && loaded[i])) begin
                count[i] <= reload[i];
                pend[i] <= 1'b0;
                null_cnt[i] <= 1'b0;
                run[i] <= 1'b1;
                out[i] <= 1'b1;
              end else if (run[i] && s.gate[i]) begin
                // Odd counts give both half-periods (count+1)/2 clocks
                if (count[i] <= COUNT_TWO) begin
                  count[i] <= reload[i];
                  pend[i] <= 1'b0;
                  null_cnt[i] <= 1'b0;
                  out[i] <= !out[i];
                end else begin
                  count[i] <= dec2[i];
                end
              end
            end
          endcase
        end

        // Low gate holds the periodic modes high at once
        if ((mode[i] == MODE_RATE || mode[i] == MODE_SQUARE) &&
            !s.gate[i]) begin
          out[i] <= 1'b1;
        end

        // Read completion walks the byte order
        if (rd_done && rsel == 2'(i)) begin
          if (status_flag[i]) begin
            status_flag[i] <= 1'b0;
          end else if (acc[i] == ACC_BOTH && !rd_hi[i]) begin
            rd_hi[i] <= 1'b1;
          end else begin
            rd_hi[i] <= 1'b0;
            latch_flag[i] <= 1'b0;
          end
        end

        if (wr_done && wsel == SEL_CONTROL) begin
          if (wdata[CW_SC +: 2] == SC_READBACK) begin
            if (wdata[RB_SEL + i]) begin
              if (!wdata[RB_NO_COUNT] && !latch_flag[i]) begin
                latched[i] <= count[i];
                latch_flag[i] <= 1'b1;
              end
              if (!wdata[RB_NO_STATUS] && !status_flag[i]) begin
                status[i] <= {out[i], null_cnt[i], acc[i], mode[i], bcd[i]};
                status_flag[i] <= 1'b1;
              end
            end
          end else if (wdata[CW_SC +: 2] == 2'(i)) begin
            if (wdata[CW_ACC +: 2] == ACC_LATCH) begin
              if (!latch_flag[i]) begin
                latched[i] <= count[i];
                latch_flag[i] <= 1'b1;
              end
            end else begin
              mode[i] <= norm_mode(wdata[CW_MODE +: 3]);
              acc[i] <= wdata[CW_ACC +: 2];
              bcd[i] <= wdata[CW_BCD];
              out[i] <= norm_mode(wdata[CW_MODE +: 3]) != MODE_TERMINAL;
              null_cnt[i] <= 1'b1;
              pend[i] <= 1'b0;
              loaded[i] <= 1'b0;
              run[i] <= 1'b0;
              wr_hi[i] <= 1'b0;
              rd_hi[i] <= 1'b0;
              latch_flag[i] <= 1'b0;
              status_flag[i] <= 1'b0;
            end
          end
        end else if (wr_done && wsel == 2'(i)) begin
          if (acc[i] == ACC_LOW ||
              (acc[i] == ACC_BOTH && !wr_hi[i])) begin
            reload[i] <= {8'h00, wdata};
          end else begin
            reload[i] <= {wdata, acc[i] == ACC_HIGH ? 8'h00 : reload[i][7:0]};
          end
          if (acc[i] == ACC_BOTH && !wr_hi[i]) begin
            wr_hi[i] <= 1'b1;
            // First byte halts a terminal count in progress
            if (mode[i] == MODE_TERMINAL) begin
              run[i] <= 1'b0;
              out[i] <= 1'b0;
            end
          end else if (acc[i] != ACC_LATCH) begin
            wr_hi[i] <= 1'b0;
            pend[i] <= 1'b1;
            loaded[i] <= 1'b1;
            null_cnt[i] <= 1'b1;
            if (mode[i] == MODE_TERMINAL) begin
              run[i] <= 1'b0;
              out[i] <= 1'b0;
            end
            if (mode[i] == MODE_SOFT_STROBE) run[i] <= 1'b0;
          end
        end
      end
    end
  end

  assign COUNTER_WAVE = out;

  // ************************************************
  // Read path
  // ************************************************
  logic [1:0] ridx;
  logic [COUNT_W-1:0] rvalue;
  logic [BUS_W-1:0] rbyte;

  always_comb begin
    ridx = (s.sel == SEL_CONTROL) ? 2'h0 : s.sel;
    rvalue = latch_flag[ridx] ? latched[ridx] : count[ridx];
    if (status_flag[ridx]) begin
      rbyte = status[ridx];
    end else if (acc[ridx] == ACC_HIGH ||
                 (acc[ridx] == ACC_BOTH && rd_hi[ridx])) begin
      rbyte = rvalue[15:8];
    end else begin
      rbyte = rvalue[7:0];
    end
  end

  // Control word reads leave the bus undriven
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      READ_BUS <= '0;
      rd_valid <= 1'b0;
    end else if (rd_start && s.sel != SEL_CONTROL) begin
      READ_BUS <= rbyte;
      rd_valid <= 1'b1;
    end else if (!rd_act) begin
      rd_valid <= 1'b0;
    end
  end

  assign READ_DRIVE_ENABLE_N = !rd_valid;

endmodule : programmable_interval_timer

// File: interval_timer_assertions.sv
// Pin-level checks on the programmable interval timer
module interval_timer_assertions
  import interval_timer_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Processor bus
  input wire logic CHIP_SELECT_N,
  input wire logic READ_STROBE_N,
  input wire logic WRITE_STROBE_N,
  input wire logic [1:0] REGISTER_SELECT,
  input wire logic [BUS_W-1:0] WRITE_BUS,
  input wire logic [BUS_W-1:0] READ_BUS,
  input wire logic READ_DRIVE_ENABLE_N,
  // Counter pins
  input wire logic [COUNTERS-1:0] COUNTER_CLOCK,
  input wire logic [COUNTERS-1:0] COUNTER_GATE,
  input wire logic [COUNTERS-1:0] COUNTER_WAVE
);
  timeunit 1ns;
  timeprecision 1ns;

  logic rd_on;
  logic [2*COUNTERS-1:0] prev_pins;
  logic [3:0] quiet;

  assign rd_on = !CHIP_SELECT_N && !READ_STROBE_N;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  always_ff @(posedge CLK) begin
    prev_pins <= {COUNTER_CLOCK, COUNTER_GATE};
  end

  // Cycles since anything that may legally move a wave
  always_ff @(posedge CLK) begin
    if (SYS_RST || !WRITE_STROBE_N
        || prev_pins != {COUNTER_CLOCK, COUNTER_GATE})
      quiet <= 4'h0;
    else if (quiet != 4'hf)
      quiet <= quiet + 4'h1;
  end

  // Sync depth is three cycles, with one cycle of slack on the late side
  a_oe_needs_read: assert property (
    !READ_DRIVE_ENABLE_N |-> $past(rd_on, 3) || $past(rd_on, 4))
    else $error("output enable low without a read");
  a_no_ctrl_read: assert property (
    !READ_DRIVE_ENABLE_N |-> $past(REGISTER_SELECT, 3) != SEL_CONTROL)
    else $error("control word register was read");
  a_oe_on_read: assert property (
    (rd_on && REGISTER_SELECT != SEL_CONTROL)[*5]
    |-> !READ_DRIVE_ENABLE_N)
    else $error("counter read not answered");
  a_oe_release: assert property (
    READ_STROBE_N[*5] |-> READ_DRIVE_ENABLE_N)
    else $error("output enable held after read");
  a_cs_gates: assert property (
    CHIP_SELECT_N[*5] |-> READ_DRIVE_ENABLE_N)
    else $error("read answered without chip select");
  a_reset_idle: assert property (
    $fell(SYS_RST) |-> READ_DRIVE_ENABLE_N && READ_BUS == 8'h00
    && COUNTER_WAVE == '0)
    else $error("outputs not idle after reset");
  a_bus_stands: assert property (
    !READ_DRIVE_ENABLE_N && $past(!READ_DRIVE_ENABLE_N)
    |-> $stable(READ_BUS))
    else $error("read data moved while enabled");
  a_wave_cause: assert property (
    quiet >= 4'h6 |-> $stable(COUNTER_WAVE))
    else $error("wave moved without clock, gate or write");
endmodule : interval_timer_assertions

// File: processor_bus_model.sv
// Processor side of the strobe bus, one access at a time
module processor_bus_model
  import interval_timer_pkg::*;
(
  // Clock
  input wire logic clk,
  // Strobes toward the timer
  output logic chip_select_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [1:0] register_select,
  output logic [BUS_W-1:0] write_bus,
  // Answer from the timer
  input wire logic [BUS_W-1:0] read_bus,
  input wire logic read_drive_enable_n
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    chip_select_n = 1'b1;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    register_select = 2'h0;
    write_bus = 8'h00;
  end

  // Pins are synchronised inside, so every phase lasts several cycles
  task automatic bus_write(input logic cs_n, input logic [1:0] sel,
                           input logic [7:0] data);
    @(posedge clk);
    chip_select_n <= cs_n;
    write_strobe_n <= 1'b0;
    register_select <= sel;
    write_bus <= data;
    repeat (4) @(posedge clk);
    chip_select_n <= 1'b1;
    write_strobe_n <= 1'b1;
    // A released bus must not keep showing the old byte
    write_bus <= ~data;
    repeat (5) @(posedge clk);
  endtask : bus_write

  task automatic bus_read(input logic cs_n, input logic [1:0] sel,
                          output logic [7:0] data, output logic seen);
    int n;
    @(posedge clk);
    chip_select_n <= cs_n;
    read_strobe_n <= 1'b0;
    register_select <= sel;
    seen = 1'b0;
    data = 8'h00;
    n = 0;
    while (!seen && n < 8) begin
      @(negedge clk);
      if (read_drive_enable_n === 1'b0) begin
        seen = 1'b1;
        data = read_bus;
      end
      n++;
    end
    repeat (3) @(posedge clk);
    chip_select_n <= 1'b1;
    read_strobe_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask : bus_read
endmodule : processor_bus_model

// File: tb.sv
// Self-checking bench for the programmable interval timer
module tb
  import interval_timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk, sys_rst, chip_select_n, read_strobe_n, write_strobe_n;
  logic [1:0] register_select;
  logic [7:0] write_bus, read_bus, rd_data;
  logic read_drive_enable_n, rd_seen;
  logic [2:0] counter_clock, counter_gate, counter_wave;
  int err_count = 0;
  int n_checks = 0;
  int cycles = 0;

  programmable_interval_timer u_programmable_interval_timer (
    .CLK(clk), .SYS_RST(sys_rst), .CHIP_SELECT_N(chip_select_n),
    .READ_STROBE_N(read_strobe_n), .WRITE_STROBE_N(write_strobe_n),
    .REGISTER_SELECT(register_select), .WRITE_BUS(write_bus),
    .READ_BUS(read_bus), .READ_DRIVE_ENABLE_N(read_drive_enable_n),
    .COUNTER_CLOCK(counter_clock), .COUNTER_GATE(counter_gate),
    .COUNTER_WAVE(counter_wave));

  processor_bus_model u_processor_bus_model (
    .clk(clk), .chip_select_n(chip_select_n),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .register_select(register_select), .write_bus(write_bus),
    .read_bus(read_bus), .read_drive_enable_n(read_drive_enable_n));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // A run needs about 700 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      $display("[FAIL] %0t run timed out", $time);
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  task automatic chk_byte(input logic [7:0] got, exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_byte

  task automatic chk_bit(input logic got, exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : chk_bit

  task automatic wr(input logic [1:0] sel, input logic [7:0] data);
    u_processor_bus_model.bus_write(1'b0, sel, data);
  endtask : wr

  task automatic rd(input logic [1:0] sel, input logic [7:0] exp);
    u_processor_bus_model.bus_read(1'b0, sel, rd_data, rd_seen);
    chk_bit(rd_seen, 1'b1, "read answered");
    chk_byte(rd_data, exp, "read byte");
  endtask : rd

  task automatic pulse(input int idx, input int n);
    repeat (n) begin
      @(posedge clk);
      counter_clock[idx] <= 1'b1;
      repeat (3) @(posedge clk);
      counter_clock[idx] <= 1'b0;
      repeat (3) @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask : pulse

  // Gate level held long enough to pass the synchroniser
  task automatic gate_set(input int idx, input logic v);
    @(posedge clk);
    counter_gate[idx] <= v;
    repeat (5) @(posedge clk);
  endtask : gate_set

  task automatic t_reset();
    @(negedge clk);
    chk_bit(read_drive_enable_n, 1'b1, "enable idle");
    chk_byte(read_bus, 8'h00, "read bus idle");
    chk_byte({5'h00, counter_wave}, 8'h00, "waves idle");
  endtask : t_reset

  task automatic t_select();
    u_processor_bus_model.bus_write(1'b1, SEL_CONTROL, 8'h54);
    chk_bit(counter_wave[1], 1'b0, "write ignored");
    wr(SEL_CONTROL, 8'h54);
    wr(2'h1, 8'h03);
    repeat (4) @(posedge clk);
    chk_bit(counter_wave[1], 1'b1, "rate mode wave");
    u_processor_bus_model.bus_read(1'b1, 2'h1, rd_data, rd_seen);
    chk_bit(rd_seen, 1'b0, "read ignored");
    u_processor_bus_model.bus_read(1'b0, SEL_CONTROL, rd_data, rd_seen);
    chk_bit(rd_seen, 1'b0, "control unreadable");
  endtask : t_select

  task automatic t_binary();
    wr(SEL_CONTROL, 8'h30);
    wr(2'h0, 8'h34);
    wr(2'h0, 8'h12);
    pulse(0, 6);
    wr(SEL_CONTROL, 8'h00);
    rd(2'h0, 8'h2f);
    rd(2'h0, 8'h12);
    chk_bit(counter_wave[0], 1'b0, "count wave low");
    pulse(1, 4);
    wr(SEL_CONTROL, 8'hd2);
    rd(2'h0, 8'h2f);
    rd(2'h0, 8'h12);
  endtask : t_binary

  task automatic t_status();
    wr(SEL_CONTROL, 8'he2);
    rd(2'h0, 8'h30);
  endtask : t_status

  task automatic t_bcd();
    wr(SEL_CONTROL, 8'hb1);
    wr(2'h2, 8'h00);
    wr(2'h2, 8'h01);
    pulse(2, 4);
    wr(SEL_CONTROL, 8'h80);
    rd(2'h2, 8'h97);
    rd(2'h2, 8'h00);
  endtask : t_bcd

  // Count of four: two clocks high, two low
  task automatic t_square();
    wr(SEL_CONTROL, 8'h56);
    wr(2'h1, 8'h04);
    pulse(1, 3);
    chk_bit(counter_wave[1], 1'b0, "square low half");
    pulse(1, 2);
    chk_bit(counter_wave[1], 1'b1, "square high half");
    pulse(1, 2);
    chk_bit(counter_wave[1], 1'b0, "square low again");
    gate_set(1, 1'b0);
    chk_bit(counter_wave[1], 1'b1, "low gate forces high");
    gate_set(1, 1'b1);
  endtask : t_square

  task automatic t_oneshot();
    wr(SEL_CONTROL, 8'h12);
    wr(2'h0, 8'h02);
    pulse(0, 2);
    chk_bit(counter_wave[0], 1'b1, "one-shot waits");
    gate_set(0, 1'b0);
    gate_set(0, 1'b1);
    pulse(0, 1);
    chk_bit(counter_wave[0], 1'b0, "one-shot fired");
    pulse(0, 2);
    chk_bit(counter_wave[0], 1'b1, "one-shot ended");
  endtask : t_oneshot

  task automatic t_strobes();
    wr(SEL_CONTROL, 8'h98);
    wr(2'h2, 8'h02);
    pulse(2, 3);
    chk_bit(counter_wave[2], 1'b0, "soft strobe low");
    pulse(2, 1);
    chk_bit(counter_wave[2], 1'b1, "soft strobe ends");
    wr(SEL_CONTROL, 8'h9a);
    wr(2'h2, 8'h01);
    gate_set(2, 1'b0);
    gate_set(2, 1'b1);
    pulse(2, 2);
    chk_bit(counter_wave[2], 1'b0, "hard strobe low");
    pulse(2, 1);
    chk_bit(counter_wave[2], 1'b1, "hard strobe ends");
  endtask : t_strobes

  // Reset in mid-run must drop every programmed wave
  task automatic t_rerun();
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_reset();
  endtask : t_rerun

  initial begin
    sys_rst = 1'b1;
    counter_clock = 3'h0;
    counter_gate = 3'h7;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_select();
    t_binary();
    t_status();
    t_bcd();
    t_square();
    t_oneshot();
    t_strobes();
    t_rerun();
    conclude();
  end
endmodule : tb

bind programmable_interval_timer interval_timer_assertions
  u_interval_timer_assertions (
  .CLK(CLK), .SYS_RST(SYS_RST), .CHIP_SELECT_N(CHIP_SELECT_N),
  .READ_STROBE_N(READ_STROBE_N), .WRITE_STROBE_N(WRITE_STROBE_N),
  .REGISTER_SELECT(REGISTER_SELECT), .WRITE_BUS(WRITE_BUS),
  .READ_BUS(READ_BUS), .READ_DRIVE_ENABLE_N(READ_DRIVE_ENABLE_N),
  .COUNTER_CLOCK(COUNTER_CLOCK), .COUNTER_GATE(COUNTER_GATE),
  .COUNTER_WAVE(COUNTER_WAVE));
